//--- core/gpf_defines.vh
`ifndef GPF_DEFINES_VH
`define GPF_DEFINES_VH

// register byte offsets
`define GPF_ADDR_CFG1         12'h000
`define GPF_ADDR_CFG2         12'h004
`define GPF_ADDR_STATE        12'h008
`define GPF_ADDR_SHORT        12'h00C
`define GPF_ADDR_FAULT2       12'h010
`define GPF_ADDR_FAULT1       12'h014
`define GPF_ADDR_SYSCFG1      12'h018
`define GPF_ADDR_MASK         12'h01C
`define GPF_ADDR_MODE         12'h020
`define GPF_ADDR_TH_BASE      12'h040
`define GPF_ADDR_MEAS_BASE    12'h080

// function select encodings
`define GPF_FN_ANA_RATIO      2'h0
`define GPF_FN_ANA_SINGLE     2'h1
`define GPF_FN_DIN            2'h2
`define GPF_FN_DOUT           2'h3

// config register two fields
`define GPF_CFG2_WAKE_BIT     8
`define GPF_CFG2_FWD_BIT      9
`define GPF_CFG2_TRIG_BIT     10

// system config register one fields
`define GPF_SYS_WAVE_BIT      0
`define GPF_SYS_OFF_LSB       1

// operating modes
`define GPF_MODE_NORMAL       2'h0
`define GPF_MODE_SLEEP        2'h1
`define GPF_MODE_DIAG         2'h2

// heartbeat timing
`define GPF_HB_ON_US          100
`define GPF_HB_OFF_STEP_US    100
`define GPF_CLK_MHZ           100
`define GPF_HB_ON_CYC         (`GPF_HB_ON_US * `GPF_CLK_MHZ)
`define GPF_HB_STEP_CYC       (`GPF_HB_OFF_STEP_US * `GPF_CLK_MHZ)

// reset values
`define GPF_CFG1_RST          14'h0000
`define GPF_TH_OT_RST         16'hFFFF
`define GPF_TH_UT_RST         16'h0000

`endif

//--- core/gpf_port.v
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "gpf_defines.vh"

module gpf_port #(
    parameter NPORT     = 7,
    parameter RES_W     = 16,
    parameter OFF_W     = 3,
    parameter HB_ON     = `GPF_HB_ON_CYC,
    parameter HB_STEP   = `GPF_HB_STEP_CYC
) (
    // apb
    input  wire                  pclk,
    input  wire                  presetn,
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [11:0]           paddr,
    input  wire [31:0]           pwdata,
    output wire                  pready,
    output reg  [31:0]           prdata,
    output wire                  pslverr,
    // port pins
    input  wire [NPORT-1:0]      pin_in,
    output reg  [NPORT-1:0]      pin_out,
    output reg  [NPORT-1:0]      pin_oe,
    // converter side
    input  wire                  conv_valid,
    input  wire [2:0]            conv_port,
    input  wire [RES_W-1:0]      conv_result,
    output reg                   conv_start,
    // system side
    output reg                   wake_event,
    output reg                   sense_route_en,
    output reg                   fault_out
);

    localparam CW = 32;

    // registers
    reg  [2*NPORT-1:0] port_config_reg_one;
    reg  [NPORT+3:0]   port_config_reg_two;
    reg  [NPORT-1:0]   pin_short_open_status_reg;
    reg  [NPORT-1:0]   short_mask;
    reg  [OFF_W:0]     system_config_reg_one;
    reg  [1:0]         op_mode;
    reg                analog_over_temp_flag;
    reg                analog_under_temp_flag;
    reg  [RES_W-1:0]   ot_th  [0:NPORT-1];
    reg  [RES_W-1:0]   ut_th  [0:NPORT-1];
    reg  [RES_W-1:0]   analog_port_result_reg [0:NPORT-1];

    // pin synchroniser
    reg  [NPORT-1:0]   sync_a;
    reg  [NPORT-1:0]   port_state_reg;
    reg  [NPORT-1:0]   state_d;

    // heartbeat
    reg  [CW-1:0]      hb_cnt;
    reg                hb_phase;

    wire [OFF_W-1:0]   heartbeat_off_time_select = system_config_reg_one[`GPF_SYS_OFF_LSB+OFF_W-1:`GPF_SYS_OFF_LSB];
    wire               wave_en = system_config_reg_one[`GPF_SYS_WAVE_BIT];
    wire [NPORT-1:0]   pin_drive_level = port_config_reg_two[NPORT-1:0];
    wire               port0_wake_enable = port_config_reg_two[`GPF_CFG2_WAKE_BIT];
    wire               port0_fault_forward_enable = port_config_reg_two[`GPF_CFG2_FWD_BIT];
    wire               port2_trigger_enable = port_config_reg_two[`GPF_CFG2_TRIG_BIT];

    function [1:0] fsel;
        input [2*NPORT-1:0] cfg;
        input integer       idx;
        begin
            fsel = cfg[2*idx +: 2];
        end
    endfunction

    wire wr = psel & penable & pwrite;
    wire rd = psel & ~penable & ~pwrite;
    localparam [11:0] NP12 = NPORT;
    wire [11:0] th_end   = `GPF_ADDR_TH_BASE + 12'h004 * NP12;
    wire [11:0] meas_end = `GPF_ADDR_MEAS_BASE + 12'h004 * NP12;
    wire [2:0]  th_idx   = paddr[4:2];

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // output direction and drive
    integer i;
    reg [NPORT-1:0] is_out;
    reg [NPORT-1:0] is_in;
    reg [NPORT-1:0] next_short;
    // drive and enable delayed to line up with the two-flop pin sample
    reg [NPORT-1:0] drv_d1;
    reg [NPORT-1:0] drv_d2;
    reg [NPORT-1:0] oe_d1;
    reg [NPORT-1:0] oe_d2;
    always @* begin
        for (i = 0; i < NPORT; i = i + 1) begin
            is_out[i] = (fsel(port_config_reg_one, i) == `GPF_FN_DOUT);
            is_in[i]  = (fsel(port_config_reg_one, i) == `GPF_FN_DIN);
            next_short[i] = is_out[i] & (port_state_reg[i] != drv_d2[i]);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= {NPORT{1'b0}};
            pin_oe  <= {NPORT{1'b0}};
        end else begin
            pin_out <= pin_drive_level & is_out;
            pin_oe  <= is_out;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a         <= {NPORT{1'b0}};
            port_state_reg <= {NPORT{1'b0}};
            state_d        <= {NPORT{1'b0}};
        end else begin
            sync_a         <= pin_in;
            port_state_reg <= sync_a;
            state_d        <= port_state_reg;
        end
    end

    // short flags: hardware set wins over software clear
    // compare against what was on the pin two cycles ago, so a drive change is no false short
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_d1                    <= {NPORT{1'b0}};
            drv_d2                    <= {NPORT{1'b0}};
            oe_d1                     <= {NPORT{1'b0}};
            oe_d2                     <= {NPORT{1'b0}};
            pin_short_open_status_reg <= {NPORT{1'b0}};
        end else begin
            drv_d1 <= pin_out;
            drv_d2 <= drv_d1;
            oe_d1  <= pin_oe;
            oe_d2  <= oe_d1;
            if (wr && paddr == `GPF_ADDR_SHORT)
                pin_short_open_status_reg <= (pin_short_open_status_reg & ~pwdata[NPORT-1:0]) |
                                             (next_short & oe_d2);
            else
                pin_short_open_status_reg <= pin_short_open_status_reg | (next_short & oe_d2);
        end
    end

    wire any_pin_short_flag = |pin_short_open_status_reg;

    // edges on port 0 and port 2
    wire p0_edge = port_state_reg[0] ^ state_d[0];
    wire p2_rise = port_state_reg[2] & ~state_d[2];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_event     <= 1'b0;
            conv_start     <= 1'b0;
            sense_route_en <= 1'b0;
        end else begin
            wake_event <= is_in[0] & port0_wake_enable & p0_edge;
            conv_start <= is_in[2] & port2_trigger_enable & p2_rise & (op_mode != `GPF_MODE_SLEEP);
            sense_route_en <= (op_mode == `GPF_MODE_DIAG);
        end
    end

    wire [2:0] cp = conv_port;
    wire [1:0] cp_fn = fsel(port_config_reg_one, cp);
    wire cv_ok = conv_valid & (cp < NPORT) & ~cp_fn[1];
    wire next_ot = cv_ok & (conv_result > ot_th[cp]);
    wire next_ut = cv_ok & (conv_result < ut_th[cp]);

    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_over_temp_flag  <= 1'b0;
            analog_under_temp_flag <= 1'b0;
            for (k = 0; k < NPORT; k = k + 1) begin
                analog_port_result_reg[k] <= {RES_W{1'b0}};
            end
        end else begin
            if (cv_ok)
                analog_port_result_reg[cp] <= conv_result;
            if (wr && paddr == `GPF_ADDR_FAULT1) begin
                analog_over_temp_flag  <= (analog_over_temp_flag & ~pwdata[0]) | next_ot;
                analog_under_temp_flag <= (analog_under_temp_flag & ~pwdata[1]) | next_ut;
            end else begin
                analog_over_temp_flag  <= analog_over_temp_flag | next_ot;
                analog_under_temp_flag <= analog_under_temp_flag | next_ut;
            end
        end
    end

    // configuration writes
    integer j;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_config_reg_one   <= `GPF_CFG1_RST;
            port_config_reg_two   <= {(NPORT+4){1'b0}};
            short_mask            <= {NPORT{1'b0}};
            system_config_reg_one <= {(OFF_W+1){1'b0}};
            op_mode               <= `GPF_MODE_NORMAL;
            for (j = 0; j < NPORT; j = j + 1) begin
                ot_th[j] <= `GPF_TH_OT_RST;
                ut_th[j] <= `GPF_TH_UT_RST;
            end
        end else if (wr) begin
            if (paddr == `GPF_ADDR_CFG1)
                port_config_reg_one <= pwdata[2*NPORT-1:0];
            if (paddr == `GPF_ADDR_CFG2)
                port_config_reg_two <= pwdata[NPORT+3:0];
            if (paddr == `GPF_ADDR_MASK)
                short_mask <= pwdata[NPORT-1:0];
            if (paddr == `GPF_ADDR_SYSCFG1)
                system_config_reg_one <= pwdata[OFF_W:0];
            if (paddr == `GPF_ADDR_MODE)
                op_mode <= pwdata[1:0];
            if (paddr >= `GPF_ADDR_TH_BASE && paddr < th_end) begin
                ot_th[th_idx] <= pwdata[31:16];
                ut_th[th_idx] <= pwdata[15:0];
            end
        end
    end

    wire fault_any = |(pin_short_open_status_reg & ~short_mask) | analog_over_temp_flag |
                     analog_under_temp_flag |
                     (port0_fault_forward_enable & is_in[0] & port_state_reg[0]);

    wire chain_hb = port0_fault_forward_enable & is_in[0];

    // high fixed, low time from duty field
    wire [CW-1:0] off_len = HB_STEP * ({{(CW-OFF_W){1'b0}}, heartbeat_off_time_select} + 32'h00000001);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hb_cnt   <= {CW{1'b0}};
            hb_phase <= 1'b0;
        end else if (!wave_en) begin
            hb_cnt   <= {CW{1'b0}};
            hb_phase <= 1'b0;
        end else if (hb_phase ? (hb_cnt >= HB_ON - 1) : (hb_cnt >= off_len - 1)) begin
            hb_cnt   <= {CW{1'b0}};
            hb_phase <= ~hb_phase;
        end else begin
            hb_cnt <= hb_cnt + 32'h00000001;
        end
    end

    // no mode gating on the fault output
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fault_out <= 1'b0;
        else if (!wave_en)
            fault_out <= fault_any;
        else if (chain_hb)
            // pass upstream wave; local fault stops it
            fault_out <= port_state_reg[0] &
                         ~(|(pin_short_open_status_reg & ~short_mask) | analog_over_temp_flag |
                           analog_under_temp_flag);
        else
            // local heartbeat, held low on fault
            fault_out <= hb_phase & ~fault_any;
    end

    // read mux
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd) begin
            prdata <= 32'h00000000;
            if (paddr == `GPF_ADDR_CFG1)
                prdata[2*NPORT-1:0] <= port_config_reg_one;
            else if (paddr == `GPF_ADDR_CFG2)
                prdata[NPORT+3:0] <= port_config_reg_two;
            else if (paddr == `GPF_ADDR_STATE)
                prdata[NPORT-1:0] <= port_state_reg;
            else if (paddr == `GPF_ADDR_SHORT)
                prdata[NPORT-1:0] <= pin_short_open_status_reg;
            else if (paddr == `GPF_ADDR_FAULT2)
                prdata[0] <= any_pin_short_flag;
            else if (paddr == `GPF_ADDR_FAULT1)
                prdata[1:0] <= {analog_under_temp_flag, analog_over_temp_flag};
            else if (paddr == `GPF_ADDR_SYSCFG1)
                prdata[OFF_W:0] <= system_config_reg_one;
            else if (paddr == `GPF_ADDR_MASK)
                prdata[NPORT-1:0] <= short_mask;
            else if (paddr == `GPF_ADDR_MODE)
                prdata[1:0] <= op_mode;
            else if (paddr >= `GPF_ADDR_TH_BASE && paddr < th_end)
                prdata <= {ot_th[th_idx], ut_th[th_idx]};
            else if (paddr >= `GPF_ADDR_MEAS_BASE && paddr < meas_end)
                prdata[RES_W-1:0] <= analog_port_result_reg[th_idx];
        end
    end

endmodule // gpf_port

//--- verification/gpf_port_props.sv
`timescale 1ns/100ps
`include "gpf_defines.vh"
module gpf_port_props #(
    parameter HB_ON   = 4,
    parameter HB_STEP = 4
) (
    // apb
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // pins and events
    input wire [6:0]  pin_in,
    input wire [6:0]  pin_out,
    input wire [6:0]  pin_oe,
    input wire        conv_start,
    input wire        wake_event,
    input wire        sense_route_en,
    input wire        fault_out
);
    reg [13:0] c1;
    reg [10:0] c2;
    reg [6:0]  mk;
    reg [3:0]  sy;
    reg [1:0]  md;
    reg [1:0]  age;
    reg [2:0]  mis;
    reg        hbc;
    reg [15:0] hi;
    reg [15:0] lo;
    reg [6:0]  oe_x;
    integer    k;
    wire       wr = psel && penable && pwrite;
    wire       ok = age == 2'h3;
    wire       hb = ok && sy[0] && !c2[9];
    // shadow config; pin, fault and sense outputs judged only after three quiet cycles, wake and trigger pulses at any time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {c1, c2, mk, sy, md, age, mis, hbc, hi, lo} <= 76'h0;
        end else begin
            if (wr && paddr == `GPF_ADDR_CFG1) c1 <= pwdata[13:0];
            if (wr && paddr == `GPF_ADDR_CFG2) c2 <= pwdata[10:0];
            if (wr && paddr == `GPF_ADDR_MASK) mk <= pwdata[6:0];
            if (wr && paddr == `GPF_ADDR_SYSCFG1) sy <= pwdata[3:0];
            if (wr && paddr == `GPF_ADDR_MODE) md <= pwdata[1:0];
            age <= wr ? 2'h0 : (ok ? age : age + 2'h1);
            mis <= ~|((pin_in ^ pin_out) & pin_oe) ? 3'h0 : (&mis ? mis : mis + 3'h1);
            hbc <= !wr && (hbc || (hi != 16'h0 && !fault_out));
            hi <= fault_out ? hi + 16'h1 : 16'h0;
            lo <= fault_out ? 16'h0 : lo + 16'h1;
        end
    end
    always @* begin
        for (k = 0; k < 7; k = k + 1)
            oe_x[k] = c1[2*k +: 2] == `GPF_FN_DOUT;
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_OUT_ENABLE: assert property (ok |-> pin_oe == oe_x)
        else $error("output enable differs from port function");
    AST_DRIVE_LEVEL: assert property (ok |-> (pin_out & pin_oe) == (c2[6:0] & pin_oe))
        else $error("driven level differs from drive bit");
    AST_SHORT_FAULT: assert property (mis == 3'h7 && ok && !sy[0] && mk == 7'h00 |-> fault_out)
        else $error("unmasked short left fault output low");
    AST_CHAIN_LEVEL: assert property ((ok && !sy[0] && c1[1:0] == `GPF_FN_DIN && c2[9] && pin_in[0])[*5] |-> fault_out)
        else $error("port 0 level not forwarded");
    AST_HB_HIGH: assert property ($fell(fault_out) && hb |-> hi == HB_ON)
        else $error("heartbeat high time wrong");
    AST_HB_LOW: assert property ($rose(fault_out) && hb && hbc |-> lo == HB_STEP * (sy[3:1] + 1))
        else $error("heartbeat low time wrong");
    AST_SENSE_ROUTE: assert property (ok |-> sense_route_en == (md == `GPF_MODE_DIAG))
        else $error("sense routing differs from mode");
    AST_TRIG_PULSE: assert property (conv_start |-> c1[5:4] == `GPF_FN_DIN && c2[10] && md != `GPF_MODE_SLEEP
        && $past(pin_in[2], 2) ##1 !conv_start)
        else $error("conversion start without enabled trigger");
    AST_WAKE_PULSE: assert property (wake_event |-> c1[1:0] == `GPF_FN_DIN && c2[8] ##1 !wake_event)
        else $error("wake pulse without enable");
endmodule // gpf_port_props

bind gpf_port gpf_port_props #(.HB_ON(HB_ON), .HB_STEP(HB_STEP)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .conv_start(conv_start), .wake_event(wake_event), .sense_route_en(sense_route_en),
    .fault_out(fault_out)
);

//--- verification/gpf_pins_model.sv
`timescale 1ns/100ps
module gpf_pins_model (
    // design side
    input  wire [6:0] pin_out,
    input  wire [6:0] pin_oe,
    // bench controls
    input  wire [6:0] ext_lvl,
    input  wire [6:0] short_en,
    // pin levels
    output wire [6:0] pin_in
);
    assign pin_in = (pin_oe & (pin_out ^ short_en)) | (~pin_oe & ext_lvl);
endmodule // gpf_pins_model

//--- verification/gpio_port_fault_daisy_chain_tb_top.sv
`timescale 1ns/100ps
`include "gpf_defines.vh"
module gpio_port_fault_daisy_chain_tb_top;
    localparam HB_ON   = 4;
    localparam HB_STEP = 4;
    // rows: address, write data, read-back
    localparam [76*7-1:0] ROWS = {
        {`GPF_ADDR_CFG1, 32'h00002AAA, 32'h00002AAA},
        {`GPF_ADDR_CFG2, 32'h00000755, 32'h00000755},
        {`GPF_ADDR_SYSCFG1, 32'h0000000A, 32'h0000000A},
        {`GPF_ADDR_MASK, 32'h0000002A, 32'h0000002A},
        {`GPF_ADDR_MODE, 32'h00000002, 32'h00000002},
        {`GPF_ADDR_TH_BASE + 12'h008, 32'h12345678, 32'h12345678},
        {12'h0F0, 32'hFFFFFFFF, 32'h00000000}};
    reg        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_valid = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rd;
    reg [2:0]  conv_port = 3'h0;
    reg [15:0] conv_result = 16'h0;
    reg [6:0]  ext_lvl = 7'h00, short_en = 7'h00;
    reg [75:0] row;
    wire       pready, pslverr, conv_start, wake_event, sense_route_en, fault_out;
    wire [31:0] prdata;
    wire [6:0] pin_in, pin_out, pin_oe;
    integer    n_fail = 0, cmp_count = 0, i, t, c, n_wake = 0, n_conv = 0;
    gpf_port #(.HB_ON(HB_ON), .HB_STEP(HB_STEP)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .conv_valid(conv_valid),
        .conv_port(conv_port), .conv_result(conv_result), .conv_start(conv_start),
        .wake_event(wake_event), .sense_route_en(sense_route_en), .fault_out(fault_out));
    gpf_pins_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
        .short_en(short_en), .pin_in(pin_in));
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (wake_event === 1'b1) n_wake <= n_wake + 1;
        if (conv_start === 1'b1) n_conv <= n_conv + 1;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rc(input [11:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, e);
        end
    endtask
    task waitc(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    task cnt(input v);
        begin
            c = 0;
            while (fault_out === v && c < 200) begin
                @(posedge pclk);
                c = c + 1;
            end
        end
    endtask
    task conv(input [15:0] r);
        begin
            conv_valid <= 1'b1;
            conv_port <= 3'h1;
            conv_result <= r;
            @(posedge pclk);
            conv_valid <= 1'b0;
        end
    endtask
    task print_verdict;
        begin
            $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict;
    end
    initial begin
        waitc(5);
        presetn <= 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            row = ROWS[76*i +: 76];
            apb(1'b1, row[75:64], row[63:32]);
            rc(row[75:64], row[31:0]);
        end
        $display("test rows done");
        // second reset while in diagnostic mode
        presetn <= 1'b0;
        waitc(5);
        chk(sense_route_en, 0);
        presetn <= 1'b1;
        rc(`GPF_ADDR_CFG1, `GPF_CFG1_RST);
        rc(`GPF_ADDR_TH_BASE, {`GPF_TH_OT_RST, `GPF_TH_UT_RST});
        $display("test reset done");
        apb(1'b1, `GPF_ADDR_CFG1, 32'h3FFF);
        apb(1'b1, `GPF_ADDR_CFG2, 32'h55);
        waitc(6);
        chk(pin_oe, 32'h7F);
        chk(pin_out, 32'h55);
        rc(`GPF_ADDR_STATE, 32'h55);
        rc(`GPF_ADDR_FAULT2, 32'h0);
        chk(fault_out, 0);
        short_en <= 7'h08;
        waitc(8);
        rc(`GPF_ADDR_SHORT, 32'h08);
        rc(`GPF_ADDR_FAULT2, 32'h1);
        chk(fault_out, 1);
        rc(`GPF_ADDR_STATE, 32'h5D);
        short_en <= 7'h00;
        waitc(6);
        apb(1'b1, `GPF_ADDR_SHORT, 32'h7F);
        rc(`GPF_ADDR_FAULT2, 32'h0);
        chk(fault_out, 0);
        apb(1'b1, `GPF_ADDR_MASK, 32'h08);
        short_en <= 7'h08;
        waitc(8);
        rc(`GPF_ADDR_SHORT, 32'h08);
        chk(fault_out, 0);
        short_en <= 7'h00;
        waitc(6);
        apb(1'b1, `GPF_ADDR_SHORT, 32'h7F);
        apb(1'b1, `GPF_ADDR_MASK, 32'h0);
        $display("test shorts done");
        apb(1'b1, `GPF_ADDR_CFG1, 32'h2AAA);
        ext_lvl <= 7'h2C;
        apb(1'b1, `GPF_ADDR_CFG2, 32'h100);
        waitc(6);
        rc(`GPF_ADDR_STATE, 32'h2C);
        t = n_wake;
        ext_lvl <= 7'h2D;
        waitc(6);
        ext_lvl <= 7'h2C;
        waitc(6);
        chk(n_wake - t, 2);
        apb(1'b1, `GPF_ADDR_CFG2, 32'h400);
        t = n_conv;
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b1, `GPF_ADDR_MODE, i);
            ext_lvl <= 7'h28;
            waitc(6);
            ext_lvl <= 7'h2C;
            waitc(6);
        end
        chk(n_conv - t, 1);
        $display("test events done");
        // host chains faults: port 0 input, wake off, forward on
        apb(1'b1, `GPF_ADDR_CFG2, 32'h200);
        for (i = 0; i < 3; i = i + 1) begin
            apb(1'b1, `GPF_ADDR_MODE, i);
            ext_lvl <= 7'h2D;
            waitc(6);
            chk(fault_out, 1);
            chk(sense_route_en, i == 2);
            ext_lvl <= 7'h2C;
            waitc(6);
            chk(fault_out, 0);
        end
        apb(1'b1, `GPF_ADDR_CFG2, 32'h0);
        for (i = 0; i < 3; i = i + 2) begin
            apb(1'b1, `GPF_ADDR_MODE, i);
            apb(1'b1, `GPF_ADDR_SYSCFG1, i * 2 + 1);
            cnt(1'b0);
            cnt(1'b1);
            cnt(1'b0);
            chk(c, HB_STEP * (i + 1));
            cnt(1'b1);
            chk(c, HB_ON);
            apb(1'b1, `GPF_ADDR_SYSCFG1, 32'h0);
        end
        apb(1'b1, `GPF_ADDR_SYSCFG1, 32'h1);
        apb(1'b1, `GPF_ADDR_CFG2, 32'h200);
        ext_lvl <= 7'h2D;
        waitc(8);
        chk(fault_out, 1);
        ext_lvl <= 7'h2C;
        waitc(8);
        chk(fault_out, 0);
        apb(1'b1, `GPF_ADDR_SYSCFG1, 32'h0);
        $display("test fault line done");
        apb(1'b1, `GPF_ADDR_CFG1, 32'h4);
        apb(1'b1, `GPF_ADDR_TH_BASE + 12'h004, 32'h08000100);
        conv(16'h0900);
        rc(`GPF_ADDR_MEAS_BASE + 12'h004, 32'h0900);
        rc(`GPF_ADDR_FAULT1, 32'h1);
        apb(1'b1, `GPF_ADDR_FAULT1, 32'h3);
        conv(16'h0050);
        rc(`GPF_ADDR_FAULT1, 32'h2);
        apb(1'b1, `GPF_ADDR_FAULT1, 32'h3);
        conv(16'h0400);
        apb(1'b1, `GPF_ADDR_CFG1, 32'h8);
        conv(16'h0123);
        rc(`GPF_ADDR_MEAS_BASE + 12'h004, 32'h0400);
        rc(`GPF_ADDR_FAULT1, 32'h0);
        $display("test analog done");
        print_verdict;
    end
endmodule // gpio_port_fault_daisy_chain_tb_top
